// ### logic/emasp_port.v
// cycle sequencer of an external memory port: asynchronous
// setup/strobe/hold cycles and programmable synchronous cycles
// assumes one system clock; output clocks are divided from it and
// every pin below is registered on the system clock
//
// Notes on behaviour
// - ready input passes a two-flop synchroniser
// - ready looked at from two ticks before end
// - ready low stretches strobe one tick each
// - strobe ends two ticks after ready high
// - six per-space async counts from configuration
// - read selects held for setup and hold
// - write selects and data held likewise
// - selects are cs, bytes, address, oe, data
// - shared pins act as async strobes
// - sync pins launched on selected clock edge
// - read latency 0..3 before data capture
// - write latency 0..3 before data drive
// - extend off: cs drops after command
// - extend on: cs follows sync output enable
// - mode 0: address strobe, deselect cycle
// - mode 1: read enable, no deselect
// - clock select picks first or second clock
// - sync settings per space in secondary word
// - shared pins act as sync strobes
// - async counts in interface clock periods
`timescale 1ns/1ps
`default_nettype none
`include "emasp_defines.vh"

module emasp_port #(
    parameter NUM_CS  = 4,
    parameter CS_W    = 2,
    parameter ADDR_W  = 20,
    parameter DATA_W  = 64,
    parameter BE_W    = 8,
    parameter ONE_DIV = `EMASP_ONE_DIV,
    parameter TWO_DIV = `EMASP_TWO_DIV
) (
    // clock and reset
    input  wire                                clock,
    input  wire                                nrst,
    // access request
    input  wire                                req_valid,
    output wire                                req_ready,
    input  wire                                req_write,
    input  wire [CS_W-1:0]                     req_space,
    input  wire [ADDR_W-1:0]                   req_addr,
    input  wire [BE_W-1:0]                     req_be,
    input  wire [DATA_W-1:0]                   req_wdata,
    // read answer
    output reg                                 rd_valid,
    output reg  [DATA_W-1:0]                   rd_data,
    // per-space configuration
    input  wire [NUM_CS-1:0]                   space_sync_mode,
    input  wire [NUM_CS*`EMASP_CNT_W-1:0]      read_setup_cycles,
    input  wire [NUM_CS*`EMASP_STB_W-1:0]      read_strobe_cycles,
    input  wire [NUM_CS*`EMASP_CNT_W-1:0]      read_hold_cycles,
    input  wire [NUM_CS*`EMASP_CNT_W-1:0]      write_setup_cycles,
    input  wire [NUM_CS*`EMASP_STB_W-1:0]      write_strobe_cycles,
    input  wire [NUM_CS*`EMASP_CNT_W-1:0]      write_hold_cycles,
    input  wire [NUM_CS*`EMASP_SEC_W-1:0]      space_secondary_control,
    // output clocks
    output wire                                ext_clock_out_one,
    output wire                                ext_clock_out_two,
    output wire                                selected_ext_clock_out,
    // memory pins
    output reg  [NUM_CS-1:0]                   chip_select_n,
    output reg  [BE_W-1:0]                     byte_enables_n,
    output wire [ADDR_W-1:0]                   ext_address,
    output wire [DATA_W-1:0]                   ext_data_bus_out,
    output reg                                 ext_data_bus_oe,
    input  wire [DATA_W-1:0]                   ext_data_bus_in,
    output reg                                 shared_oe_pin_n,
    output reg                                 shared_rd_pin_n,
    output reg                                 shared_wr_pin_n,
    input  wire                                ready_wait_input,
    // status
    output wire                                port_busy
);

    localparam STB_W = `EMASP_STB_W;
    localparam CNT_W = `EMASP_CNT_W;
    localparam SEC_W = `EMASP_SEC_W;

    // one-hot states
    localparam [6:0] ST_IDLE   = 7'h01;
    localparam [6:0] ST_SETUP  = 7'h02;
    localparam [6:0] ST_STROBE = 7'h04;
    localparam [6:0] ST_HOLD   = 7'h08;
    localparam [6:0] ST_SCMD   = 7'h10;
    localparam [6:0] ST_SLAT   = 7'h20;
    localparam [6:0] ST_STAIL  = 7'h40;

    localparam [STB_W-1:0] CNT_ONE = 1;
    localparam [STB_W-1:0] RDY_WIN = `EMASP_READY_WIN;

    // ------------
    // functions
    // ------------
    // a zero count still gives one period
    function [STB_W-1:0] at_least_one;
        input [STB_W-1:0] v;
        begin
            at_least_one = (v == {STB_W{1'b0}}) ? CNT_ONE : v;
        end
    endfunction

    // active-low select for one space
    function [NUM_CS-1:0] space_select_n;
        input [CS_W-1:0] idx;
        integer k;
        begin
            space_select_n = {NUM_CS{`EMASP_PIN_IDLE}};
            for (k = 0; k < NUM_CS; k = k + 1) begin
                if (idx == k[CS_W-1:0]) begin
                    space_select_n[k] = 1'b0;
                end
            end
        end
    endfunction

    // ------------
    // clocks and ready synchroniser
    // ------------
    wire tick_one;
    wire tick_two;
    wire rdy_s;

    // interface clock periods come from these dividers
    emasp_clkdiv #(.DIV(ONE_DIV)) u_div_one (
        .clock     (clock),
        .nrst      (nrst),
        .tick      (tick_one),
        .clk_level (ext_clock_out_one)
    );

    emasp_clkdiv #(.DIV(TWO_DIV)) u_div_two (
        .clock     (clock),
        .nrst      (nrst),
        .tick      (tick_two),
        .clk_level (ext_clock_out_two)
    );

    // ready is made safe before any use
    emasp_sync2 u_rdy_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (ready_wait_input),
        .sync_out (rdy_s)
    );

    // ------------
    // state and latched access
    // ------------
    reg [6:0]        state_r;
    reg [STB_W-1:0]  cnt_r;
    reg [STB_W-1:0]  strobe_r;
    reg [STB_W-1:0]  hold_r;
    reg              ext_r;
    reg              wr_r;
    reg [CS_W-1:0]   space_r;
    reg [ADDR_W-1:0] addr_r;
    reg [BE_W-1:0]   be_r;
    reg [DATA_W-1:0] wdata_r;
    reg [1:0]        lat_r;
    reg              csext_r;
    reg              rden_r;
    reg              clksel_r;

    wire             accept = req_valid && (state_r == ST_IDLE);
    wire [SEC_W-1:0] sec_w  = space_secondary_control[req_space*SEC_W +: SEC_W];
    wire [1:0]       rl_w   = sec_w[`EMASP_SEC_RL_LSB +: `EMASP_SEC_LAT_W];
    wire [1:0]       wl_w   = sec_w[`EMASP_SEC_WL_LSB +: `EMASP_SEC_LAT_W];
    wire             stick  = clksel_r ? tick_two : tick_one;
    wire [CNT_W-1:0] set_w  = req_write ? write_setup_cycles[req_space*CNT_W +: CNT_W]
                                        : read_setup_cycles[req_space*CNT_W +: CNT_W];
    wire [STB_W-1:0] stb_w  = req_write ? write_strobe_cycles[req_space*STB_W +: STB_W]
                                        : read_strobe_cycles[req_space*STB_W +: STB_W];
    wire [CNT_W-1:0] hld_w  = req_write ? write_hold_cycles[req_space*CNT_W +: CNT_W]
                                        : read_hold_cycles[req_space*CNT_W +: CNT_W];
    wire [STB_W-1:0] lat_x  = {{(STB_W-2){1'b0}}, lat_r};

    // a new access only from idle, after the hold or the last sync period is over
    assign req_ready = (state_r == ST_IDLE);
    assign port_busy = (state_r != ST_IDLE);

    // output clock the synchronous cycles are timed
    assign selected_ext_clock_out = clksel_r ? ext_clock_out_two : ext_clock_out_one;
    assign ext_address            = addr_r;
    assign ext_data_bus_out       = wdata_r;

    // ------------
    // sequencer
    // ------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r  <= ST_IDLE;
            cnt_r    <= {STB_W{1'b0}};
            strobe_r <= {STB_W{1'b0}};
            hold_r   <= {STB_W{1'b0}};
            ext_r    <= 1'b0;
            wr_r     <= 1'b0;
            space_r  <= {CS_W{1'b0}};
            addr_r   <= {ADDR_W{1'b0}};
            be_r     <= {BE_W{1'b0}};
            wdata_r  <= {DATA_W{1'b0}};
            lat_r    <= `EMASP_LAT_ZERO;
            csext_r  <= 1'b0;
            rden_r   <= 1'b0;
            clksel_r <= 1'b0;
            rd_valid <= 1'b0;
            rd_data  <= {DATA_W{1'b0}};
        end else begin
            rd_valid <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        wr_r    <= req_write;
                        space_r <= req_space;
                        addr_r  <= req_addr;
                        be_r    <= req_be;
                        wdata_r <= req_wdata;
                        ext_r   <= 1'b0;
                        // per-space counts and settings captured
                        cnt_r    <= at_least_one({{(STB_W-CNT_W){1'b0}}, set_w});
                        strobe_r <= at_least_one(stb_w);
                        hold_r   <= at_least_one({{(STB_W-CNT_W){1'b0}}, hld_w});
                        lat_r    <= req_write ? wl_w : rl_w;
                        csext_r  <= sec_w[`EMASP_SEC_CSEXT];
                        rden_r   <= sec_w[`EMASP_SEC_RDEN];
                        clksel_r <= sec_w[`EMASP_SEC_CLKSEL];
                        state_r  <= space_sync_mode[req_space] ? ST_SCMD : ST_SETUP;
                    end
                end
                // setup periods before the strobe falls
                ST_SETUP: begin
                    if (tick_one) begin
                        if (cnt_r == CNT_ONE) begin
                            cnt_r   <= strobe_r;
                            state_r <= ST_STROBE;
                        end else begin
                            cnt_r <= cnt_r - CNT_ONE;
                        end
                    end
                end
                ST_STROBE: begin
                    if (tick_one) begin
                        if ((cnt_r <= RDY_WIN) && !rdy_s) begin
                            // low ready inside the window holds the count
                            ext_r <= 1'b1;
                        end else if (ext_r) begin
                            // ready back high: one more period then end
                            ext_r <= 1'b0;
                            cnt_r <= CNT_ONE;
                        end else if (cnt_r == CNT_ONE) begin
                            // programmed strobe width done
                            cnt_r   <= hold_r;
                            state_r <= ST_HOLD;
                            if (!wr_r) begin
                                rd_valid <= 1'b1;
                                rd_data  <= ext_data_bus_in;
                            end
                        end else begin
                            cnt_r <= cnt_r - CNT_ONE;
                        end
                    end
                end
                // hold periods after the strobe rises
                ST_HOLD: begin
                    if (tick_one) begin
                        if (cnt_r == CNT_ONE) begin
                            state_r <= ST_IDLE;
                        end else begin
                            cnt_r <= cnt_r - CNT_ONE;
                        end
                    end
                end
                // command period on the selected clock
                ST_SCMD: begin
                    if (stick) begin
                        if (lat_r == `EMASP_LAT_ZERO) begin
                            if (!wr_r) begin
                                rd_valid <= 1'b1;
                                rd_data  <= ext_data_bus_in;
                            end
                            state_r <= rden_r ? ST_IDLE : ST_STAIL;
                        end else begin
                            cnt_r   <= lat_x;
                            state_r <= ST_SLAT;
                        end
                    end
                end
                // latency periods before data
                ST_SLAT: begin
                    if (stick) begin
                        if (cnt_r == CNT_ONE) begin
                            if (!wr_r) begin
                                rd_valid <= 1'b1;
                                rd_data  <= ext_data_bus_in;
                            end
                            // deselect period only in address strobe mode
                            state_r <= rden_r ? ST_IDLE : ST_STAIL;
                        end else begin
                            cnt_r <= cnt_r - CNT_ONE;
                        end
                    end
                end
                // deselect period, everything inactive
                ST_STAIL: begin
                    if (stick) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------
    // pin values
    // ------------
    reg [NUM_CS-1:0] cs_nxt;
    reg [BE_W-1:0]   be_nxt;
    reg              oe_nxt;
    reg              rd_nxt;
    reg              wr_nxt;
    reg              dq_oe_nxt;

    always @* begin
        cs_nxt    = {NUM_CS{`EMASP_PIN_IDLE}};
        be_nxt    = {BE_W{`EMASP_PIN_IDLE}};
        oe_nxt    = `EMASP_PIN_IDLE;
        rd_nxt    = `EMASP_PIN_IDLE;
        wr_nxt    = `EMASP_PIN_IDLE;
        dq_oe_nxt = 1'b0;
        case (state_r)
            // selects valid through setup and hold, data too on writes
            ST_SETUP, ST_HOLD: begin
                cs_nxt    = space_select_n(space_r);
                be_nxt    = ~be_r;
                oe_nxt    = wr_r;
                dq_oe_nxt = wr_r;
            end
            // shared pins as output enable, read and write strobe
            ST_STROBE: begin
                cs_nxt    = space_select_n(space_r);
                be_nxt    = ~be_r;
                oe_nxt    = wr_r;
                rd_nxt    = wr_r;
                wr_nxt    = ~wr_r;
                dq_oe_nxt = wr_r;
            end
            // shared pins as sync strobes
            ST_SCMD: begin
                cs_nxt    = space_select_n(space_r);
                be_nxt    = ~be_r;
                oe_nxt    = wr_r;
                rd_nxt    = wr_r && rden_r;
                wr_nxt    = ~wr_r;
                dq_oe_nxt = wr_r && (lat_r == `EMASP_LAT_ZERO);
            end
            ST_SLAT: begin
                // cs drops after the command unless extended with oe
                if (csext_r && !wr_r) begin
                    cs_nxt = space_select_n(space_r);
                end
                be_nxt    = ~be_r;
                oe_nxt    = wr_r;
                rd_nxt    = !(rden_r && !wr_r);
                dq_oe_nxt = wr_r && (cnt_r == CNT_ONE);
            end
            default: begin
                cs_nxt = {NUM_CS{`EMASP_PIN_IDLE}};
            end
        endcase
    end

    // pins registered; all inactive between accesses
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            chip_select_n   <= {NUM_CS{`EMASP_PIN_IDLE}};
            byte_enables_n  <= {BE_W{`EMASP_PIN_IDLE}};
            shared_oe_pin_n <= `EMASP_PIN_IDLE;
            shared_rd_pin_n <= `EMASP_PIN_IDLE;
            shared_wr_pin_n <= `EMASP_PIN_IDLE;
            ext_data_bus_oe <= 1'b0;
        end else begin
            chip_select_n   <= cs_nxt;
            byte_enables_n  <= be_nxt;
            shared_oe_pin_n <= oe_nxt;
            shared_rd_pin_n <= rd_nxt;
            shared_wr_pin_n <= wr_nxt;
            ext_data_bus_oe <= dq_oe_nxt;
        end
    end

endmodule

`default_nettype wire

// ### logic/emasp_defines.vh
// constants shared by the external memory port sequencer
// assumes inclusion by bare name from files under logic/
`ifndef EMASP_DEFINES_VH
`define EMASP_DEFINES_VH

// ------------
// counter widths
// ------------
`define EMASP_CNT_W        4
`define EMASP_STB_W        6
`define EMASP_DIV_W        8

// ------------
// interface clock dividers (system clocks per output clock period)
// ------------
`define EMASP_ONE_DIV      2
`define EMASP_TWO_DIV      4

// ------------
// ready input is looked at this many ticks before strobe end
// ------------
`define EMASP_READY_WIN    2

// ------------
// secondary control word layout, one word per chip-select space
// ------------
`define EMASP_SEC_W        7
`define EMASP_SEC_RL_LSB   0
`define EMASP_SEC_WL_LSB   2
`define EMASP_SEC_LAT_W    2
`define EMASP_SEC_CSEXT    4
`define EMASP_SEC_RDEN     5
`define EMASP_SEC_CLKSEL   6

// ------------
// idle levels
// ------------
`define EMASP_PIN_IDLE     1'b1
`define EMASP_LAT_ZERO     2'h0

`endif

// ### logic/emasp_sync2.v
// two-flop synchroniser for a level arriving from outside
// assumes the output is read only in the clock domain of clock
`timescale 1ns/1ps
`default_nettype none

module emasp_sync2 (
    // clock and reset
    input  wire clock,
    input  wire nrst,
    // level in and synchronised level out
    input  wire async_in,
    output wire sync_out
);

    reg meta_r;
    reg stable_r;

    // ------------
    // first stage feeds only the second stage
    // ------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_r   <= 1'b1;
            stable_r <= 1'b1;
        end else begin
            meta_r   <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule

`default_nettype wire

// ### logic/emasp_clkdiv.v
// divider making an output clock level and a one-cycle tick
// assumes an even DIV of at least 2 so that the level is a square wave
`timescale 1ns/1ps
`default_nettype none
`include "emasp_defines.vh"

module emasp_clkdiv #(
    parameter DIV = `EMASP_ONE_DIV
) (
    // clock and reset
    input  wire clock,
    input  wire nrst,
    // tick at the rising edge of the output clock, and its level
    output reg  tick,
    output reg  clk_level
);

    localparam [`EMASP_DIV_W-1:0] LAST = DIV - 1;
    localparam [`EMASP_DIV_W-1:0] HALF = DIV / 2;

    reg [`EMASP_DIV_W-1:0] cnt_r;
    reg [`EMASP_DIV_W-1:0] cnt_nxt;

    // ------------
    // wrap counter
    // ------------
    always @* begin
        if (cnt_r == LAST) begin
            cnt_nxt = {`EMASP_DIV_W{1'b0}};
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // level high in the first half, tick where the level rises
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_r     <= {`EMASP_DIV_W{1'b0}};
            tick      <= 1'b0;
            clk_level <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            tick      <= (cnt_r == LAST);
            clk_level <= (cnt_nxt < HALF);
        end
    end

endmodule

`default_nettype wire

// ### tb/emasp_port_sva.sv
// checker for the pins of the memory port sequencer
// assumes a bind onto emasp_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module emasp_port_sva #(
    parameter NUM_CS = 4
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              nrst,
    // watched pins
    input wire logic              req_ready,
    input wire logic              port_busy,
    input wire logic              rd_valid,
    input wire logic [NUM_CS-1:0] chip_select_n,
    input wire logic              shared_rd_pin_n,
    input wire logic              shared_wr_pin_n,
    input wire logic              ext_clock_out_one
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // ------------
    // steps
    // ------------
    sequence s_idle2;
        !port_busy ##1 !port_busy;
    endsequence
    sequence s_clk_high;
        $rose(ext_clock_out_one) ##1 !ext_clock_out_one;
    endsequence
    // ------------
    // properties
    // ------------
    chk_idle_quiet: assert property (s_idle2 |-> &chip_select_n && shared_rd_pin_n && shared_wr_pin_n)
        else $error("pins active while idle");
    chk_ready_idle: assert property (req_ready == !port_busy)
        else $error("ready and busy disagree");
    chk_one_space: assert property ($countones(~chip_select_n) <= 1)
        else $error("two spaces selected");
    chk_rd_pulse: assert property (rd_valid |=> !rd_valid)
        else $error("read valid longer than one cycle");
    chk_rd_in_access: assert property (rd_valid |-> $past(port_busy))
        else $error("read valid outside an access");
    chk_wr_selected: assert property (!shared_wr_pin_n |-> !(&chip_select_n))
        else $error("write strobe without select");
    chk_rd_min_tick: assert property ($fell(shared_rd_pin_n) |=> !shared_rd_pin_n)
        else $error("read strobe shorter than a tick");
    chk_wr_min_tick: assert property ($fell(shared_wr_pin_n) |=> !shared_wr_pin_n)
        else $error("write strobe shorter than a tick");
    chk_busy_bound: assert property ($rose(port_busy) |-> ##[1:600] !port_busy)
        else $error("access never ends");
    chk_clk_half: assert property (s_clk_high |=> ext_clock_out_one)
        else $error("output clock not a square wave");
endmodule
bind emasp_port emasp_port_sva #(.NUM_CS(NUM_CS)) u_sva (.clock(clock), .nrst(nrst),
    .req_ready(req_ready), .port_busy(port_busy), .rd_valid(rd_valid), .chip_select_n(chip_select_n),
    .shared_rd_pin_n(shared_rd_pin_n), .shared_wr_pin_n(shared_wr_pin_n),
    .ext_clock_out_one(ext_clock_out_one));
`default_nettype wire

// ### tb/emasp_mem_model.sv
// far-side memory: sixteen words and a ready line
// assumes the pins of emasp_port on one system clock
`timescale 1ns/1ps
`default_nettype none
module emasp_mem_model (
    // clock
    input wire logic        clock,
    // pins from the port
    input wire logic [3:0]  cs_n,
    input wire logic        oe_n,
    input wire logic [3:0]  addr,
    input wire logic [63:0] dout,
    input wire logic        doe,
    // pins to the port
    output wire logic [63:0] din,
    output wire logic       ready,
    // ready held low this many clocks after select
    input wire logic [7:0]  wait_clks
);
    logic [63:0] mem [0:15];
    logic [63:0] last = 64'h0000_0000_0000_0000;
    logic [7:0]  cnt  = 8'h00;
    logic        sel_d = 1'b0;
    // flow-through reads; a released bus shows the inverse of its last value
    assign din = oe_n ? ~last : mem[addr];
    always @(posedge clock) begin
        if (doe) mem[addr] <= dout;
        if (!oe_n) last <= mem[addr];
    end
    // ready low for a whole count, never a short glitch
    always @(posedge clock) begin
        sel_d <= ~&cs_n;
        if (~&cs_n && !sel_d) cnt <= wait_clks;
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
    assign ready = (cnt == 8'h00);
endmodule
`default_nettype wire

// ### tb/ext_mem_async_sync_port_test.sv
// testbench of the memory port sequencer
// assumes emasp_port, its checker and the memory model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: got %0h exp %0h", $time, a, b); end end
module ext_mem_async_sync_port_test;
    logic        clock = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0]  req_space = 2'h0;
    logic [19:0] req_addr = 20'h0_0000;
    logic [63:0] req_wdata = 64'h0000_0000_0000_0000, got = 64'h0000_0000_0000_0000;
    logic [15:0] stp = 16'h0000, hld = 16'h0000, su = 16'h0000, st = 16'h0000, ho = 16'h0000, cl = 16'h0000;
    logic [23:0] stb = 24'h00_0000;
    logic [27:0] sec = 28'h000_0000;
    logic [3:0]  mode = 4'h0, chip_select_n;
    logic [7:0]  wait_clks = 8'h00;
    logic [19:0] ext_address;
    logic [63:0] rd_data, ext_data_bus_out, ext_data_bus_in;
    logic        req_ready, rd_valid, ext_data_bus_oe, shared_oe_pin_n, shared_rd_pin_n;
    logic        shared_wr_pin_n, ready_wait_input, port_busy, clk2;
    int          num_errors = 0, checked = 0;
    emasp_port dut (.clock, .nrst, .req_valid, .req_ready, .req_write, .req_space, .req_addr,
        .req_be(8'hff), .req_wdata, .rd_valid, .rd_data, .space_sync_mode(mode),
        .read_setup_cycles(stp), .read_strobe_cycles(stb), .read_hold_cycles(hld),
        .write_setup_cycles(stp), .write_strobe_cycles(stb), .write_hold_cycles(hld),
        .space_secondary_control(sec), .ext_clock_out_one(), .ext_clock_out_two(clk2),
        .selected_ext_clock_out(), .chip_select_n, .byte_enables_n(), .ext_address,
        .ext_data_bus_out, .ext_data_bus_oe, .ext_data_bus_in, .shared_oe_pin_n,
        .shared_rd_pin_n, .shared_wr_pin_n, .ready_wait_input, .port_busy);
    emasp_mem_model u_mem (.clock, .cs_n(chip_select_n), .oe_n(shared_oe_pin_n), .addr(ext_address[3:0]),
        .dout(ext_data_bus_out), .doe(ext_data_bus_oe), .din(ext_data_bus_in), .ready(ready_wait_input),
        .wait_clks);
    // ------------
    // clock, phase counters, watchdog
    // ------------
    initial forever #50 clock = ~clock;
    // count setup, strobe, hold and select cycles
    always @(posedge clock) begin
        if (rd_valid) got <= rd_data;
        if (!(shared_rd_pin_n & shared_wr_pin_n)) st <= st + 16'h0001;
        else if (!(&chip_select_n)) begin
            if (st == 16'h0000) su <= su + 16'h0001;
            else ho <= ho + 16'h0001;
        end
        if (!(&chip_select_n)) cl <= cl + 16'h0001;
    end
    // cut a hang short
    initial begin
        #(100 * 20000);
        num_errors++;
        complete_run();
    end
    // ------------
    // tasks
    // ------------
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // set one space: setup, strobe, hold, secondary word, sync mode
    task automatic cfg(input int k, input logic [3:0] s, input logic [5:0] t, input logic [3:0] h,
                       input logic [6:0] c, input logic m);
        @(posedge clock);
        stp[k*4 +: 4] <= s;
        stb[k*6 +: 6] <= t;
        hld[k*4 +: 4] <= h;
        sec[k*7 +: 7] <= c;
        mode[k] <= m;
    endtask
    // one access, taken on a slow clock tick, then wait for idle
    task automatic acc(input logic w, input logic [1:0] sp, input logic [19:0] a, input logic [63:0] d);
        int n;
        @(negedge clock);
        su = 16'h0000;
        st = 16'h0000;
        ho = 16'h0000;
        cl = 16'h0000;
        @(posedge clock iff clk2);
        @(posedge clock iff !clk2);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_space <= sp;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        @(posedge clock);
        while (port_busy && n < 2000) begin
            @(posedge clock);
            n++;
        end
        `CHK(n < 2000, 1'b1)
        repeat (3) @(posedge clock);
    endtask
    // ------------
    // scenarios
    // ------------
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        cfg(0, 4'h2, 6'h03, 4'h2, 7'h00, 1'b0);
        acc(1'b1, 2'd0, 20'h0_0001, 64'h1111_2222_3333_4444);
        `CHK(su, 16'h0004)
        `CHK(st, 16'h0006)
        `CHK(ho, 16'h0004)
        acc(1'b0, 2'd0, 20'h0_0001, 64'h0000_0000_0000_0000);
        `CHK(su, 16'h0004)
        `CHK(ho, 16'h0004)
        `CHK(got, 64'h1111_2222_3333_4444)
        wait_clks <= 8'h0c;
        acc(1'b0, 2'd0, 20'h0_0001, 64'h0000_0000_0000_0000);
        `CHK(st > 16'h0006 && !st[0], 1'b1)
        `CHK(got, 64'h1111_2222_3333_4444)
        cfg(0, 4'h4, 6'h05, 4'h1, 7'h00, 1'b0);
        wait_clks <= 8'h04;
        acc(1'b0, 2'd0, 20'h0_0001, 64'h0000_0000_0000_0000);
        `CHK(st, 16'h000a)
        `CHK(ho, 16'h0002)
        wait_clks <= 8'h00;
        for (int l = 0; l < 4; l++) begin
            cfg(2, 4'h0, 6'h00, 4'h0, {3'b000, l[1:0], l[1:0]}, 1'b1);
            acc(1'b1, 2'd2, {16'h0000, 2'b01, l[1:0]}, {60'h0123_4567_89ab_cde, l[3:0]});
            acc(1'b0, 2'd2, {16'h0000, 2'b01, l[1:0]}, 64'h0000_0000_0000_0000);
            `CHK(got, {60'h0123_4567_89ab_cde, l[3:0]})
            `CHK(cl, 16'h0002)
            `CHK(st, 16'h0002)
        end
        cfg(2, 4'h0, 6'h00, 4'h0, 7'h3a, 1'b1);
        acc(1'b0, 2'd2, 20'h0_0006, 64'h0000_0000_0000_0000);
        `CHK(got, 64'h0123_4567_89ab_cde2)
        `CHK(cl, 16'h0006)
        `CHK(st, 16'h0006)
        cfg(3, 4'h0, 6'h00, 4'h0, 7'h40, 1'b1);
        acc(1'b0, 2'd3, 20'h0_0004, 64'h0000_0000_0000_0000);
        `CHK(cl, 16'h0004)
        `CHK(got, 64'h0123_4567_89ab_cde0)
        complete_run();
    end
endmodule
`default_nettype wire
